// >>> shared/ept_defines.vh
// Register map, field positions and reset values of the eight-channel
// PWM timer. Assumes a 32-bit word bus with byte addresses.
`ifndef EPT_DEFINES_VH
`define EPT_DEFINES_VH

// ----------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------
`define EPT_ADDR_W 12
`define EPT_OFS_STATUS 12'h000
`define EPT_OFS_RUN 12'h004
`define EPT_OFS_TMR 12'h010
`define EPT_OFS_TMR_END 12'h090
`define EPT_OFS_REV 12'h090
`define EPT_OFS_REP 12'h0a0
`define EPT_OFS_PAT 12'h0c0
`define EPT_OFS_LEN 12'h140
`define EPT_OFS_ID 12'h160
`define EPT_SPAN_WORDS8 12'h020
`define EPT_SPAN_PAT 12'h080
`define EPT_SUB_CTRL 4'h0
`define EPT_SUB_RELOAD 4'h4
`define EPT_SUB_COMPARE 4'h8
`define EPT_SUB_COUNT 4'hc

// ----------------------------------------------------------------------
// Control fields
// ----------------------------------------------------------------------
`define EPT_CTL_CLK_SRC 0
`define EPT_CTL_UPDATE 1
`define EPT_CTL_INV 2
`define EPT_CTL_MODE_LO 3
`define EPT_CTL_MODE_HI 4
`define EPT_CTL_IRQ_EN 5
`define EPT_CTL_IRQ_PULSE 6
`define EPT_CTL_DMA_EN 7
`define EPT_CTL_PWM_EN 8
`define EPT_CTL_DZ_LO 24
`define EPT_CTL_DZ_HI 31
`define EPT_CTL_MASK 32'hff0001fd
`define EPT_MODE_ONESHOT 2'h0
`define EPT_MODE_INTERVAL 2'h1
`define EPT_MODE_REPEAT 2'h2
`define EPT_MODE_PATTERN 2'h3

// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define EPT_RST_WORD 32'h0000_0000
`define EPT_REV_CODE 32'h0000_0001

`endif

// >>> logic/ept_edge_sync.v
// Two-flop synchroniser with rising-edge pulse for an external clock.
// Assumes the input is slower than half the bus clock rate.
`timescale 1ns/1ns
module ept_edge_sync
(
  // Clock and reset
  input wire i_clock,
  input wire i_rst_n,
  // Asynchronous level in, one-cycle pulse out
  input wire i_async,
  output reg o_rise
);

  reg meta;
  reg stable;
  reg prev;

  always @(posedge i_clock or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      meta <= 1'b0;
      stable <= 1'b0;
      prev <= 1'b0;
      o_rise <= 1'b0;
    end
    else
    begin
      meta <= i_async;
      stable <= meta;
      prev <= stable;
      o_rise <= stable & ~prev;
    end
  end

endmodule // ept_edge_sync

// >>> logic/ept_deadzone.v
// Dead-zone generator: a pair of complementary outputs with a gap of
// (setting - 1) bus clocks after every change of the input level.
// Assumes the input comes from a flip-flop on the same clock.
`timescale 1ns/1ns
module ept_deadzone
(
  // Clock and reset
  input wire i_clock,
  input wire i_rst_n,
  // PWM level and settings
  input wire i_level,
  input wire i_enable,
  input wire [7:0] i_setting,
  // Gapped outputs
  output reg o_gapped,
  output reg o_comp_gapped
);

  reg last;
  reg [7:0] gap;

  always @(posedge i_clock or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      last <= 1'b0;
      gap <= 8'h00;
      o_gapped <= 1'b0;
      o_comp_gapped <= 1'b0;
    end
    else
    begin
      last <= i_level;
      if (!i_enable)
      begin
        gap <= 8'h00;
        o_gapped <= 1'b0;
        o_comp_gapped <= 1'b0;
      end
      else if (i_setting <= 8'h01)
      begin
        gap <= 8'h00;
        o_gapped <= i_level;
        o_comp_gapped <= ~i_level;
      end
      else if (i_level != last)
      begin
        // Restarting on each change swallows pulses shorter than the gap
        gap <= i_setting - 8'h01;
        o_gapped <= 1'b0;
        o_comp_gapped <= 1'b0;
      end
      else if (gap > 8'h01)
      begin
        gap <= gap - 8'h01;
        o_gapped <= 1'b0;
        o_comp_gapped <= 1'b0;
      end
      else
      begin
        gap <= 8'h00;
        o_gapped <= i_level;
        o_comp_gapped <= ~i_level;
      end
    end
  end

endmodule // ept_deadzone

// >>> logic/ept_timer_top.v
// Eight down-counting PWM timers with register port, DMA handshake,
// interrupts and dead-zone outputs.
// Assumes the register master and DMA controller run on i_clock; the
// external count clock is asynchronous and much slower than i_clock.
`timescale 1ns/1ns
`include "ept_defines.vh"
module ept_timer_top
#(
  parameter [31:0] REV_CODE = `EPT_REV_CODE // Arbitrary value
)
(
  // Clock and reset
  input wire i_clock,
  input wire i_rst_n,
  // Register port
  input wire [`EPT_ADDR_W-1:0] i_addr,
  input wire [31:0] i_wdata,
  input wire i_wr,
  input wire i_rd,
  output reg [31:0] o_rdata,
  // External count clock
  input wire i_ext_clock,
  // DMA handshake
  input wire [7:0] i_dma_acknowledge,
  output reg [7:0] o_dma_request,
  // Interrupts, one per timer
  output reg [7:0] o_timer_irq,
  // PWM outputs
  output reg [7:0] o_pwm_output,
  output reg [7:0] o_pwm_output_complement,
  output wire [7:0] o_pwm_output_gapped,
  output wire [7:0] o_pwm_complement_gapped
);

  // --------------------------------------------------------------------
  // Reset release and external clock
  // --------------------------------------------------------------------
  reg rst_meta;
  reg rst_n;
  wire ext_rise;

  always @(posedge i_clock or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      rst_meta <= 1'b0;
      rst_n <= 1'b0;
    end
    else
    begin
      rst_meta <= 1'b1;
      rst_n <= rst_meta;
    end
  end

  ept_edge_sync u_ext_sync
  (
    .i_clock(i_clock),
    .i_rst_n(rst_n),
    .i_async(i_ext_clock),
    .o_rise(ext_rise)
  );

  // --------------------------------------------------------------------
  // Storage
  // --------------------------------------------------------------------
  reg [31:0] ctrl [0:7];
  reg [31:0] reload [0:7];
  reg [31:0] cmpb [0:7];
  reg [31:0] count [0:7];
  reg [31:0] cmp_live [0:7];
  reg [15:0] rep [0:7];
  reg [15:0] rep_left [0:7];
  reg [127:0] pat [0:7];
  reg [6:0] len [0:7];
  reg [6:0] pat_idx [0:7];
  reg [7:0] run;
  reg [7:0] active;
  reg [7:0] level;
  reg [7:0] upd_pend;
  reg [7:0] status;

  // --------------------------------------------------------------------
  // Address decode
  // --------------------------------------------------------------------
  wire aligned = (i_addr[1:0] == 2'b00);
  wire [`EPT_ADDR_W-1:0] tmr_rel = i_addr - `EPT_OFS_TMR;
  wire [`EPT_ADDR_W-1:0] pat_rel = i_addr - `EPT_OFS_PAT;
  wire hit_tmr = aligned && (i_addr >= `EPT_OFS_TMR) &&
                 (i_addr < `EPT_OFS_TMR_END);
  wire hit_rep = aligned && (i_addr >= `EPT_OFS_REP) &&
                 (i_addr < `EPT_OFS_REP + `EPT_SPAN_WORDS8);
  wire hit_pat = aligned && (i_addr >= `EPT_OFS_PAT) &&
                 (i_addr < `EPT_OFS_PAT + `EPT_SPAN_PAT);
  wire hit_len = aligned && (i_addr >= `EPT_OFS_LEN) &&
                 (i_addr < `EPT_OFS_LEN + `EPT_SPAN_WORDS8);
  wire [2:0] tmr_idx = tmr_rel[6:4];
  wire [3:0] tmr_sub = tmr_rel[3:0];
  wire [2:0] word_idx = i_addr[4:2];
  wire [2:0] pat_idx_sel = pat_rel[6:4];
  wire [1:0] pat_word = pat_rel[3:2];

  // Lowest-numbered pending timer wins; zero when none
  function [3:0] first_pending;
    input [7:0] flags;
    integer n;
    begin
      first_pending = 4'h0;
      for (n = 7; n >= 0; n = n - 1)
        if (flags[n])
          first_pending = n[3:0] + 4'h1;
    end
  endfunction

  // --------------------------------------------------------------------
  // Per-timer events
  // --------------------------------------------------------------------
  reg [7:0] tick;
  reg [7:0] zero_ev;
  reg [7:0] finish;
  reg [7:0] irq_ev;
  reg [7:0] dma_ev;
  reg [7:0] raw;
  reg [3:0] c;
  reg [1:0] m;

  always @*
  begin
    tick = 8'h00;
    zero_ev = 8'h00;
    finish = 8'h00;
    irq_ev = 8'h00;
    dma_ev = 8'h00;
    raw = 8'h00;
    m = 2'b00;
    for (c = 4'h0; c < 4'h8; c = c + 4'h1)
    begin
      m = ctrl[c[2:0]][`EPT_CTL_MODE_HI:`EPT_CTL_MODE_LO];
      tick[c[2:0]] = run[c[2:0]] & active[c[2:0]] &
        (ctrl[c[2:0]][`EPT_CTL_CLK_SRC] ? ext_rise : 1'b1);
      zero_ev[c[2:0]] = tick[c[2:0]] &
        (count[c[2:0]] == 32'h0000_0000);
      case (m)
        `EPT_MODE_ONESHOT:
          finish[c[2:0]] = 1'b1;
        `EPT_MODE_REPEAT:
          finish[c[2:0]] = (rep_left[c[2:0]] == 16'h0000);
        `EPT_MODE_PATTERN:
          finish[c[2:0]] = (rep_left[c[2:0]] == 16'h0000) &&
            (pat_idx[c[2:0]] == len[c[2:0]]);
        default:
          finish[c[2:0]] = 1'b0;
      endcase
      // Repeat and pattern modes report once, at the end of the last pass; interval reports every pass
      irq_ev[c[2:0]] = zero_ev[c[2:0]] &
        ((m == `EPT_MODE_INTERVAL) | finish[c[2:0]]) &
        ctrl[c[2:0]][`EPT_CTL_IRQ_EN] &
        ~ctrl[c[2:0]][`EPT_CTL_DMA_EN];
      dma_ev[c[2:0]] = zero_ev[c[2:0]] &
        ctrl[c[2:0]][`EPT_CTL_DMA_EN];
      if (m == `EPT_MODE_PATTERN)
        raw[c[2:0]] = pat[c[2:0]][pat_idx[c[2:0]]];
      else
        raw[c[2:0]] = level[c[2:0]] ^ ctrl[c[2:0]][`EPT_CTL_INV];
    end
  end

  // --------------------------------------------------------------------
  // Registers and counters
  // --------------------------------------------------------------------
  reg [3:0] k;
  wire [7:0] tmr_hit = (i_wr && hit_tmr) ? (8'h01 << tmr_idx) : 8'h00;

  always @(posedge i_clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      run <= 8'h00;
      active <= 8'h00;
      level <= 8'h00;
      upd_pend <= 8'h00;
      status <= 8'h00;
      o_dma_request <= 8'h00;
      o_timer_irq <= 8'h00;
      o_pwm_output <= 8'h00;
      o_pwm_output_complement <= 8'h00;
      for (k = 4'h0; k < 4'h8; k = k + 4'h1)
      begin
        ctrl[k[2:0]] <= `EPT_RST_WORD;
        reload[k[2:0]] <= `EPT_RST_WORD;
        cmpb[k[2:0]] <= `EPT_RST_WORD;
        count[k[2:0]] <= `EPT_RST_WORD;
        cmp_live[k[2:0]] <= `EPT_RST_WORD;
        rep[k[2:0]] <= 16'h0000;
        rep_left[k[2:0]] <= 16'h0000;
        pat[k[2:0]] <= 128'h0;
        len[k[2:0]] <= 7'h00;
        pat_idx[k[2:0]] <= 7'h00;
      end
    end
    else
    begin
      if (i_wr && aligned && (i_addr == `EPT_OFS_RUN))
        run <= i_wdata[7:0];
      // A new event beats a clear in the same cycle
      status <= (status & ~((i_wr && aligned &&
        (i_addr == `EPT_OFS_STATUS)) ? i_wdata[7:0] : 8'h00)) |
        irq_ev;
      o_dma_request <= (o_dma_request & ~i_dma_acknowledge) |
        dma_ev;
      for (k = 4'h0; k < 4'h8; k = k + 4'h1)
      begin
        if (tmr_hit[k[2:0]] && (tmr_sub == `EPT_SUB_CTRL))
          ctrl[k[2:0]] <= i_wdata & `EPT_CTL_MASK;
        upd_pend[k[2:0]] <= tmr_hit[k[2:0]] && (tmr_sub == `EPT_SUB_CTRL) &&
          i_wdata[`EPT_CTL_UPDATE];
        if (tmr_hit[k[2:0]] && (tmr_sub == `EPT_SUB_RELOAD))
          reload[k[2:0]] <= i_wdata;
        if (tmr_hit[k[2:0]] && (tmr_sub == `EPT_SUB_COMPARE))
          cmpb[k[2:0]] <= i_wdata;
        if (i_wr && hit_rep && (word_idx == k[2:0]))
          rep[k[2:0]] <= i_wdata[15:0];
        if (i_wr && hit_len && (word_idx == k[2:0]))
          len[k[2:0]] <= i_wdata[6:0];
        if (i_wr && hit_pat && (pat_idx_sel == k[2:0]))
        begin
          case (pat_word)
            2'h0: pat[k[2:0]][31:0] <= i_wdata;
            2'h1: pat[k[2:0]][63:32] <= i_wdata;
            2'h2: pat[k[2:0]][95:64] <= i_wdata;
            default: pat[k[2:0]][127:96] <= i_wdata;
          endcase
        end
        if (upd_pend[k[2:0]])
        begin
          count[k[2:0]] <= reload[k[2:0]];
          cmp_live[k[2:0]] <= cmpb[k[2:0]];
          level[k[2:0]] <= 1'b0;
          rep_left[k[2:0]] <= rep[k[2:0]];
          pat_idx[k[2:0]] <= 7'h00;
          active[k[2:0]] <= 1'b1;
        end
        else if (zero_ev[k[2:0]])
        begin
          if (finish[k[2:0]])
            active[k[2:0]] <= 1'b0;
          else
          begin
            count[k[2:0]] <= reload[k[2:0]];
            cmp_live[k[2:0]] <= cmpb[k[2:0]];
            level[k[2:0]] <= 1'b0;
            if (ctrl[k[2:0]][`EPT_CTL_MODE_HI:`EPT_CTL_MODE_LO] ==
                `EPT_MODE_REPEAT)
              rep_left[k[2:0]] <= rep_left[k[2:0]] - 16'h0001;
            if (ctrl[k[2:0]][`EPT_CTL_MODE_HI:`EPT_CTL_MODE_LO] ==
                `EPT_MODE_PATTERN)
            begin
              if (pat_idx[k[2:0]] == len[k[2:0]])
              begin
                pat_idx[k[2:0]] <= 7'h00;
                rep_left[k[2:0]] <= rep_left[k[2:0]] - 16'h0001;
              end
              else
                pat_idx[k[2:0]] <= pat_idx[k[2:0]] + 7'h01;
            end
          end
        end
        else if (tick[k[2:0]])
        begin
          count[k[2:0]] <= count[k[2:0]] - 32'h0000_0001;
          if (count[k[2:0]] - 32'h0000_0001 == cmp_live[k[2:0]])
            level[k[2:0]] <= 1'b1;
        end
        // Pulse form gives one cycle per event; level form follows status
        if (ctrl[k[2:0]][`EPT_CTL_IRQ_PULSE])
          o_timer_irq[k[2:0]] <= irq_ev[k[2:0]];
        else
          o_timer_irq[k[2:0]] <= (status[k[2:0]] & ~((i_wr && aligned &&
            (i_addr == `EPT_OFS_STATUS)) ? i_wdata[k[2:0]] : 1'b0)) |
            irq_ev[k[2:0]];
        o_pwm_output[k[2:0]] <= ctrl[k[2:0]][`EPT_CTL_PWM_EN] &
          raw[k[2:0]];
        o_pwm_output_complement[k[2:0]] <=
          ctrl[k[2:0]][`EPT_CTL_PWM_EN] & ~raw[k[2:0]];
      end
    end
  end

  // --------------------------------------------------------------------
  // Dead-zone outputs
  // --------------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < 8; g = g + 1)
    begin : dz
      ept_deadzone u_dz
      (
        .i_clock(i_clock),
        .i_rst_n(rst_n),
        .i_level(o_pwm_output[g]),
        .i_enable(o_pwm_output[g] | o_pwm_output_complement[g]),
        .i_setting(ctrl[g][`EPT_CTL_DZ_HI:`EPT_CTL_DZ_LO]),
        .o_gapped(o_pwm_output_gapped[g]),
        .o_comp_gapped(o_pwm_complement_gapped[g])
      );
    end
  endgenerate

  // --------------------------------------------------------------------
  // Read port
  // --------------------------------------------------------------------
  reg [31:0] next_rdata;

  always @*
  begin
    next_rdata = 32'h0000_0000;
    if (hit_tmr)
    begin
      case (tmr_sub)
        `EPT_SUB_CTRL:
          next_rdata = ctrl[tmr_idx] |
            {30'h0, upd_pend[tmr_idx], 1'b0};
        `EPT_SUB_RELOAD: next_rdata = reload[tmr_idx];
        `EPT_SUB_COMPARE: next_rdata = cmpb[tmr_idx];
        default: next_rdata = count[tmr_idx];
      endcase
    end
    else if (hit_rep)
      next_rdata = {16'h0000, rep[word_idx]};
    else if (hit_len)
      next_rdata = {25'h0, len[word_idx]};
    else if (hit_pat)
    begin
      case (pat_word)
        2'h0: next_rdata = pat[pat_idx_sel][31:0];
        2'h1: next_rdata = pat[pat_idx_sel][63:32];
        2'h2: next_rdata = pat[pat_idx_sel][95:64];
        default: next_rdata = pat[pat_idx_sel][127:96];
      endcase
    end
    else if (aligned)
    begin
      case (i_addr)
        `EPT_OFS_STATUS: next_rdata = {24'h0, status};
        `EPT_OFS_RUN: next_rdata = {24'h0, run};
        `EPT_OFS_REV: next_rdata = REV_CODE;
        `EPT_OFS_ID:
          next_rdata = {28'h0, first_pending(status)};
        default: next_rdata = 32'h0000_0000;
      endcase
    end
  end

  always @(posedge i_clock or negedge rst_n)
  begin
    if (!rst_n)
      o_rdata <= 32'h0000_0000;
    else if (i_rd)
      o_rdata <= next_rdata;
    else
      o_rdata <= 32'h0000_0000;
  end

endmodule // ept_timer_top

// >>> tb/ept_timer_assertions.sv
// Port-level checker for the eight-timer PWM block.
// Assumes one clock domain; bound to the top module from the bench.
`timescale 1ns/1ns
module ept_checker
(
  // Clock and reset
  input wire i_clock,
  input wire i_rst_n,
  // Observed ports
  input wire i_rd,
  input wire [31:0] o_rdata,
  input wire [7:0] i_dma_acknowledge,
  input wire [7:0] o_dma_request,
  input wire [7:0] o_timer_irq,
  input wire [7:0] o_pwm_output,
  input wire [7:0] o_pwm_output_complement,
  input wire [7:0] o_pwm_output_gapped,
  input wire [7:0] o_pwm_complement_gapped
);
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (!i_rst_n);
  // --------------------------------------------------------------
  // Register port and reset
  // --------------------------------------------------------------
  rdata_idle_a: assert property (
    !$past(i_rd) |-> o_rdata == 32'h0)
    else $error("read data outside its slot");
  reset_quiet_a: assert property (!$past(i_rst_n) |->
    (o_dma_request | o_timer_irq | o_pwm_output) == 8'h0)
    else $error("outputs active right after reset");
  // --------------------------------------------------------------
  // DMA handshake
  // --------------------------------------------------------------
  dma_hold_a: assert property (|o_dma_request |=>
    ($past(o_dma_request & ~i_dma_acknowledge) & ~o_dma_request) == 8'h0)
    else $error("request dropped without acknowledge");
  dma_no_irq_a: assert property (
    ((o_dma_request & ~$past(o_dma_request)) &
    (o_timer_irq & ~$past(o_timer_irq))) == 8'h0)
    else $error("interrupt raised with a request");
  // --------------------------------------------------------------
  // PWM and dead-zone outputs
  // --------------------------------------------------------------
  pwm_excl_a: assert property (
    (o_pwm_output & o_pwm_output_complement) == 8'h0)
    else $error("output and complement both high");
  gap_excl_a: assert property (
    (o_pwm_output_gapped & o_pwm_complement_gapped) == 8'h0)
    else $error("gapped pair both high");
  gap_rise_a: assert property ((o_pwm_output_gapped &
    ~$past(o_pwm_output_gapped) & ~$past(o_pwm_output)) == 8'h0)
    else $error("gapped output rose while output low");
  comp_rise_a: assert property ((o_pwm_complement_gapped &
    ~$past(o_pwm_complement_gapped) &
    ~$past(o_pwm_output_complement)) == 8'h0)
    else $error("gapped complement rose while complement low");
  gap_fall_a: assert property (
    (o_pwm_output_gapped & ~$past(o_pwm_output) &
    ~$past(o_pwm_output, 2)) == 8'h0)
    else $error("gapped output stayed high");
  cover property (|(o_dma_request & i_dma_acknowledge));
  cover property (|o_timer_irq);
  cover property (|o_pwm_output_gapped);
  cover property (o_rdata != 32'h0);
endmodule // ept_checker

// >>> tb/ept_dma_model.sv
// Behavioural DMA channel set: one acknowledge per request.
// Assumes requests are levels on the bus clock.
`timescale 1ns/1ns
module ept_dma_model
(
  // Clock and reset
  input wire i_clock,
  input wire i_rst_n,
  // Slow mode waits three extra cycles before each acknowledge after the first
  input wire i_slow,
  input wire [7:0] i_request,
  output reg [7:0] o_ack,
  output reg [31:0] o_ack_total
);
  reg [2:0] wait_cnt [0:7];
  integer k;
  always @(posedge i_clock or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      o_ack <= 8'h0;
      o_ack_total <= 32'h0;
      for (k = 0; k < 8; k = k + 1)
        wait_cnt[k] <= 3'h0;
    end
    else
    begin
      o_ack_total <= o_ack_total + 32'($countones(o_ack));
      for (k = 0; k < 8; k = k + 1)
      begin
        // Only a pending request is answered, never a stale one
        o_ack[k] <= i_request[k] && !o_ack[k] &&
          (wait_cnt[k] == 3'h0);
        if (i_request[k] && !o_ack[k])
        begin
          if (wait_cnt[k] == 3'h0)
            wait_cnt[k] <= i_slow ? 3'h3 : 3'h0;
          else
            wait_cnt[k] <= wait_cnt[k] - 3'h1;
        end
      end
    end
  end
endmodule // ept_dma_model

// >>> tb/test_ept_timer_top.sv
// Self-checking bench for the eight-timer PWM block.
// Assumes the register map of the shared defines and the DMA model.
`timescale 1ns/1ns
`include "ept_defines.vh"
module test_ept_timer_top;
  localparam [31:0] REV = 32'h5a5a_0001; // Arbitrary value
  localparam [31:0] UP = 32'h2;
  localparam [31:0] IE = 32'h20;
  localparam [31:0] PU = 32'h40;
  localparam [31:0] DM = 32'h80;
  localparam [31:0] PW = 32'h100;
  reg i_clock = 1'b0;
  reg i_rst_n = 1'b0;
  reg [11:0] i_addr = 12'h0;
  reg [31:0] i_wdata = 32'h0;
  reg i_wr = 1'b0;
  reg i_rd = 1'b0;
  reg i_ext_clock = 1'b0;
  reg slow = 1'b0;
  reg prev;
  reg [11:0] a;
  reg [31:0] d, m;
  wire [31:0] o_rdata, ack_total;
  wire [7:0] ack, req, irq, pwm, pwm_n, gap, gap_n;
  integer failures = 0;
  integer check_count = 0;
  integer cycles = 0;
  integer n, r, c, dz, k, i, h, hi, ghi, chi, ni, irqc, rises;
  always #5 i_clock = ~i_clock;
  // Off the bus grid so the synchroniser sees a truly foreign edge
  always #23 i_ext_clock = ~i_ext_clock;
  ept_timer_top #(.REV_CODE(REV)) dut_u (.i_clock(i_clock),
    .i_rst_n(i_rst_n), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr),
    .i_rd(i_rd), .o_rdata(o_rdata), .i_ext_clock(i_ext_clock),
    .i_dma_acknowledge(ack), .o_dma_request(req), .o_timer_irq(irq),
    .o_pwm_output(pwm), .o_pwm_output_complement(pwm_n),
    .o_pwm_output_gapped(gap), .o_pwm_complement_gapped(gap_n));
  ept_dma_model dma_u (.i_clock(i_clock), .i_rst_n(i_rst_n),
    .i_slow(slow), .i_request(req), .o_ack(ack), .o_ack_total(ack_total));
  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function [11:0] ta(input integer t, input integer s);
    ta = 12'(16 + 16 * t + s);
  endfunction
  function integer hi_exp(input integer inv, input integer pr,
    input integer pc);
    hi_exp = inv ? pr - pc : pc + 1;
  endfunction
  function integer gap_of(input integer z);
    gap_of = z > 1 ? z - 1 : 0;
  endfunction
  task automatic wr(input [11:0] wa, input [31:0] v);
  begin
    @(posedge i_clock);
    i_wr <= 1'b1;
    i_addr <= wa;
    i_wdata <= v;
    @(posedge i_clock);
    i_wr <= 1'b0;
  end
  endtask
  task automatic rd(input [11:0] ra, output [31:0] v);
  begin
    @(posedge i_clock);
    i_rd <= 1'b1;
    i_addr <= ra;
    @(posedge i_clock);
    i_rd <= 1'b0;
    #1 v = o_rdata;
  end
  endtask
  task automatic chk_reg(input [31:0] got, input [31:0] exp);
  begin
    check_count = check_count + 1;
    if (got !== exp)
    begin
      failures = failures + 1;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  end
  endtask
  task automatic chk_cnt(input integer got, input integer exp);
  begin
    check_count = check_count + 1;
    if (got !== exp)
    begin
      failures = failures + 1;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  end
  endtask
  task automatic chk_rd(input [11:0] ra, input [31:0] exp);
  begin
    rd(ra, d);
    chk_reg(d, exp);
  end
  endtask
  task automatic measure(input integer t, input integer len);
  begin
    hi = 0;
    ghi = 0;
    chi = 0;
    ni = 0;
    irqc = 0;
    rises = 0;
    prev = pwm[t];
    repeat (len)
    begin
      @(posedge i_clock);
      #1;
      hi = hi + pwm[t];
      ghi = ghi + gap[t];
      chi = chi + gap_n[t];
      ni = ni + pwm_n[t];
      irqc = irqc + irq[t];
      rises = rises + (pwm[t] & ~prev);
      prev = pwm[t];
    end
  end
  endtask
  task automatic stop_clear(input integer t);
  begin
    wr(`EPT_OFS_RUN, 32'h0);
    wr(ta(t, 0), 32'h0);
    wr(`EPT_OFS_STATUS, 32'hff);
  end
  endtask
  task automatic wrap_up;
  begin
    $display("checks=%0d failures=%0d", check_count, failures);
    if (failures == 0 && check_count > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  end
  endtask
  always @(posedge i_clock)
  begin
    cycles = cycles + 1;
    if (cycles == 20000)
    begin
      failures = failures + 1;
      wrap_up;
    end
  end
  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial
  begin
    void'($urandom(32'h69af));
    repeat (3) @(posedge i_clock);
    i_rst_n <= 1'b1;
    repeat (3) @(posedge i_clock);
    chk_rd(`EPT_OFS_REV, REV);
    chk_rd(`EPT_OFS_STATUS, 32'h0);
    chk_rd(`EPT_OFS_ID, 32'h0);
    chk_rd(ta(7, 0), 32'h0);
    chk_rd(12'h200, 32'h0);
    for (i = 0; i < 24; i = i + 1)
    begin
      n = $urandom_range(7);
      k = $urandom_range(5);
      d = $urandom;
      if (k == 0)
        d[1] = 1'b0;
      a = k < 3 ? ta(n, 4 * k) : k == 3 ? 12'(160 + 4 * n)
        : k == 4 ? 12'(192 + 16 * n + 4 * (i % 4)) : 12'(320 + 4 * n);
      m = k == 0 ? `EPT_CTL_MASK : k == 3 ? 32'hffff
        : k == 5 ? 32'h7f : 32'hffffffff;
      wr(a, d);
      chk_rd(a, d & m);
    end
    wr(ta(2, 12), 32'h55);
    chk_rd(ta(2, 12), 32'h0);
    wr(`EPT_OFS_RUN, 32'h1a5);
    chk_rd(`EPT_OFS_RUN, 32'ha5);
    wr(`EPT_OFS_RUN, 32'h0);
    for (i = 0; i < 4; i = i + 1)
    begin
      n = $urandom_range(7);
      r = $urandom_range(11, 8);
      // Compare stays above every dead-zone setting drawn below
      c = $urandom_range(r - 4, 4);
      dz = $urandom_range(3);
      h = hi_exp(i % 2, r, c);
      wr(ta(n, 4), r);
      wr(ta(n, 8), c);
      wr(ta(n, 0), UP | PW | IE | 32'h8 | (i % 2) << 2 | dz << 24);
      wr(`EPT_OFS_RUN, 32'h1 << n);
      repeat (2 * r) @(posedge i_clock);
      measure(n, 8 * (r + 1));
      chk_cnt(hi, 8 * h);
      chk_cnt(ni, 8 * (r + 1 - h));
      chk_cnt(ghi, 8 * (h - gap_of(dz)));
      chk_cnt(chi, 8 * (r + 1 - h - gap_of(dz)));
      chk_reg(irq[n], 1'b1);
      chk_rd(`EPT_OFS_ID, n + 1);
      stop_clear(n);
      chk_rd(`EPT_OFS_ID, 32'h0);
      chk_reg(irq[n], 1'b0);
    end
    n = $urandom_range(7);
    wr(ta(n, 4), 32'h5);
    wr(ta(n, 0), UP | IE | PU);
    wr(`EPT_OFS_RUN, 32'h1 << n);
    measure(n, 40);
    chk_cnt(irqc, 1);
    chk_rd(ta(n, 12), 32'h0);
    stop_clear(n);
    k = $urandom_range(3, 1);
    wr(ta(n, 4), 32'h4);
    wr(ta(n, 8), 32'h2);
    wr(12'(160 + 4 * n), k);
    wr(ta(n, 0), UP | PW | IE | PU | 32'h10);
    wr(`EPT_OFS_RUN, 32'h1 << n);
    measure(n, 5 * (k + 1) + 30);
    chk_cnt(rises, k + 1);
    chk_cnt(irqc, 1);
    stop_clear(n);
    // Pattern: bits 0 and 3 low so only bits 1 and 2 add high time
    m = ($urandom & 32'hfffffff6) | 32'h2;
    wr(12'(160 + 4 * n), 32'h1);
    wr(12'(192 + 16 * n), m);
    wr(12'(320 + 4 * n), 32'h3);
    wr(ta(n, 4), 32'h3);
    wr(`EPT_OFS_RUN, 32'h1 << n);
    wr(ta(n, 0), UP | PW | IE | PU | 32'h18 | 32'h4);
    measure(n, 50);
    chk_cnt(hi, 8 * (1 + m[2]));
    chk_cnt(irqc, 1);
    stop_clear(n);
    for (i = 0; i < 2; i = i + 1)
    begin
      slow <= i[0];
      wr(ta(n, 4), 32'h7);
      wr(ta(n, 0), UP | DM | IE | 32'h8);
      wr(`EPT_OFS_RUN, 32'h1 << n);
      d = ack_total;
      measure(n, 64);
      chk_cnt(irqc, 0);
      chk_cnt(ack_total - d >= 7 && ack_total - d <= 9, 1);
      stop_clear(n);
    end
    wr(ta(n, 4), 32'h20);
    wr(ta(n, 0), UP | 32'h1);
    wr(`EPT_OFS_RUN, 32'h1 << n);
    repeat (20) @(posedge i_clock);
    wr(ta(n, 4), 32'h1000);
    rd(ta(n, 12), d);
    chk_cnt(d > 32'h18 && d < 32'h20, 1);
    chk_rd(ta(n, 4), 32'h1000);
    wrap_up;
  end
endmodule // test_ept_timer_top
bind ept_timer_top ept_checker chk_u (.i_clock(i_clock), .i_rst_n(i_rst_n),
  .i_rd(i_rd), .o_rdata(o_rdata), .i_dma_acknowledge(i_dma_acknowledge),
  .o_dma_request(o_dma_request), .o_timer_irq(o_timer_irq),
  .o_pwm_output(o_pwm_output),
  .o_pwm_output_complement(o_pwm_output_complement),
  .o_pwm_output_gapped(o_pwm_output_gapped),
  .o_pwm_complement_gapped(o_pwm_complement_gapped));
